// [usbhp_consts.svh]
`ifndef USBHP_CONSTS_SVH
`define USBHP_CONSTS_SVH

// register offsets on the processor address lines
`define USBHP_REG_EP_SEL 8'h00
`define USBHP_REG_EP_CFG 8'h02
`define USBHP_REG_STATUS 8'h04
`define USBHP_REG_ALLOC 8'h06
`define USBHP_REG_DMA_CMD 8'h08
`define USBHP_REG_DMA_COUNT 8'h0a

// endpoint configuration and dma command word layout
`define USBHP_EPCFG_EN_BIT 15
`define USBHP_EPCFG_DBL_BIT 14
`define USBHP_EPCFG_TYPE_HI 13
`define USBHP_EPCFG_TYPE_LO 12
`define USBHP_EPCFG_PKT_HI 10
`define USBHP_DMACMD_DIR_BIT 0
`define USBHP_DMACMD_MASTER_BIT 1

// endpoint indices of the two control endpoints
`define USBHP_EP_CTRL_OUT 4'h0
`define USBHP_EP_CTRL_IN 4'h8

// buffer sizes in bytes
`define USBHP_BUF_BYTES 16'h2000
`define USBHP_CTRL_BYTES 16'h0040
`define USBHP_SETUP_BYTES 16'h0008

// clock figures
`define USBHP_SYS_MHZ 125
`define USBHP_OSC_MHZ 12
`define USBHP_PLL_MULT 6'h28
`define USBHP_OSC_TIMEOUT ((2 * `USBHP_SYS_MHZ + `USBHP_OSC_MHZ - 1) / `USBHP_OSC_MHZ)

// master dma strobe timing
`define USBHP_SYS_PERIOD_NS 8
`define USBHP_DMA_STROBE_NS 24
`define USBHP_DMA_GAP_NS 16
`define USBHP_DMA_STROBE_CYC ((`USBHP_DMA_STROBE_NS + `USBHP_SYS_PERIOD_NS - 1) / `USBHP_SYS_PERIOD_NS)
`define USBHP_DMA_GAP_CYC ((`USBHP_DMA_GAP_NS + `USBHP_SYS_PERIOD_NS - 1) / `USBHP_SYS_PERIOD_NS)

`endif

// [usbhp_pkg.sv]
package usbhp_pkg;

	typedef enum logic [3:0] {
		DMA_IDLE = 4'b0001,
		DMA_SLAVE = 4'b0010,
		DMA_M_ON = 4'b0100,
		DMA_M_OFF = 4'b1000
	} usbhp_dma_e;

	typedef struct packed {
		logic enable;
		logic dblBuf;
		logic [1:0] epType;
		logic [10:0] maxPkt;
	} usbhp_epcfg_s;

	typedef struct packed {
		logic csN;
		logic strobeA;
		logic strobeB;
		logic aleOrIndicator;
		logic [7:0] ad;
	} usbhp_cpuin_s;

	typedef struct packed {
		logic [15:0] data;
		logic valid;
	} usbhp_word_s;

	typedef struct packed {
		logic cfgDone;
		logic busGeneric;
		logic strobeSep;
		logic latchInd;
		logic [7:0] addrLatch;
		logic strobePrev;
		logic accValid;
		logic accWrite;
		logic accAddrPhase;
		logic [7:0] accAddr;
		logic [15:0] wrData;
		logic [15:0] rdData;
		logic [7:0] adOut;
		logic adOe;
		logic [15:0] dataOut;
		logic dataOe;
		logic [15:0] txWord;
		logic [3:0] epSel;
		usbhp_epcfg_s [15:0] ep;
		logic [15:0] allocBytes;
		logic allocRefused;
		logic dmaArmed;
		logic dmaDirOut;
		logic dmaMaster;
		logic [15:0] dmaCount;
		usbhp_dma_e dmaState;
		logic [3:0] dmaTimer;
		logic dmaRdPrev;
		logic dmaWrPrev;
		logic [15:0] dmaLatch;
		usbhp_word_s rxWord;
		logic txPop;
		logic mRdN;
		logic mWrN;
		logic wakePrev;
		logic wakeReq;
		logic oscPrev;
		logic [4:0] oscTimer;
	} usbhp_state_s;

endpackage

// [usbhp_host_bus_port.sv]
// Behaviour
// - bus select high: local lines are only the register address.
// - generic mode: wide lines shared; host read and dma never driven together.
// - bus select low: local lines multiplex address and data.
// - split mode: wide lines carry dma data only.
// - generic mode: dma runs as slave only, on dma strobes.
// - split mode: dma may run as master or slave.
// - strobe style picks direction plus data strobe or separate strobes, with chip select.
// - split mode: latch style picks address latch strobe or address/data indicator.
// - bus select captured at power-up fixes the configuration.
// - dma data bus stays undriven until a dma command runs.
// - control outputs are always driven.
// - rising remote wake input while suspended raises a wake request.
// - sixteen endpoints plus a setup buffer are kept.
// - control endpoints are fixed at 64 bytes.
// - each data endpoint is enabled or disabled by software.
// - each data endpoint has its own type and packet size.
// - data endpoints may be double buffered.
// - 8 kbytes of buffer shared by the control endpoints, the setup buffer and the enabled data endpoints.
// - internal sampling clock is forty times the 12 MHz reference.
// - bus speed is detected without the processor.
// - strobe style high: separate read/write strobes; low: direction and data strobe.
// - latch style low: latch strobe; high: address/data indicator.
//
// Added by the designer: strobed register access and the address map.
`include "usbhp_consts.svh"

module usbhp_host_bus_port (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// configuration straps
	input wire logic hostBusSelect,
	input wire logic strobeStyleSelect,
	input wire logic latchStyleSelect,
	// processor bus
	input wire usbhp_pkg::usbhp_cpuin_s cpuIn,
	output logic [7:0] adOut,
	output logic adOe,
	// wide data lines
	input wire logic [15:0] dataIn,
	output logic [15:0] dataOut,
	output logic dataOe,
	// dma strobes
	input wire logic dmaReadStrobeN,
	input wire logic dmaWriteStrobeN,
	output logic dmaMasterReadN,
	output logic dmaMasterWriteN,
	// dma user side
	input wire logic [15:0] dmaTxData,
	output logic dmaTxPop,
	output usbhp_pkg::usbhp_word_s dmaRx,
	// core status and wake
	input wire logic highSpeedDetected,
	input wire logic suspended,
	input wire logic remoteWakeInput,
	input wire logic oscReferenceInput,
	output logic remoteWakeRequest,
	// configuration towards the core
	output usbhp_pkg::usbhp_epcfg_s [15:0] epConfig,
	output logic busGeneric
);

	usbhp_pkg::usbhp_state_s q;
	usbhp_pkg::usbhp_state_s d;

	// control endpoints sit outside software reach
	function automatic logic isCtrl(input logic [3:0] idx);
		isCtrl = (idx == `USBHP_EP_CTRL_OUT) || (idx == `USBHP_EP_CTRL_IN);
	endfunction

	// bytes claimed by the control, setup and enabled data endpoints
	function automatic logic [15:0] allocSum(input usbhp_pkg::usbhp_epcfg_s [15:0] e);
		logic [15:0] sum;
		sum = `USBHP_CTRL_BYTES + `USBHP_CTRL_BYTES + `USBHP_SETUP_BYTES;
		for (int i = 0; i < 16; i++) begin
			if (!isCtrl(4'(i)) && e[i].enable) begin
				sum = sum + (e[i].dblBuf ? {4'h0, e[i].maxPkt, 1'b0} : {5'h00, e[i].maxPkt});
			end
		end
		allocSum = sum;
	endfunction

	// word seen by the processor at an even register offset
	function automatic logic [15:0] regWord(input usbhp_pkg::usbhp_state_s st, input logic [7:0] a);
		usbhp_pkg::usbhp_epcfg_s c;
		c = st.ep[st.epSel];
		case ({a[7:1], 1'b0})
			`USBHP_REG_EP_SEL: regWord = {12'h000, st.epSel};
			`USBHP_REG_EP_CFG: regWord = {c.enable, c.dblBuf, c.epType, 1'b0, c.maxPkt};
			`USBHP_REG_STATUS: regWord = {1'b0, st.allocRefused, `USBHP_PLL_MULT,
				st.dmaState != usbhp_pkg::DMA_IDLE, st.dmaArmed,
				st.oscTimer < 5'(`USBHP_OSC_TIMEOUT), suspended,
				highSpeedDetected, st.latchInd, st.strobeSep, st.busGeneric};
			`USBHP_REG_ALLOC: regWord = st.allocBytes;
			`USBHP_REG_DMA_CMD: regWord = {14'h0000, st.dmaMaster, st.dmaDirOut};
			`USBHP_REG_DMA_COUNT: regWord = st.dmaCount;
			default: regWord = 16'h0000;
		endcase
	endfunction

	// state after reset
	function automatic usbhp_pkg::usbhp_state_s resetState();
		usbhp_pkg::usbhp_state_s st;
		st = '0;
		st.dmaState = usbhp_pkg::DMA_IDLE;
		st.mRdN = 1'b1;
		st.mWrN = 1'b1;
		st.ep[`USBHP_EP_CTRL_OUT].maxPkt = 11'(`USBHP_CTRL_BYTES);
		st.ep[`USBHP_EP_CTRL_IN].maxPkt = 11'(`USBHP_CTRL_BYTES);
		st.allocBytes = `USBHP_CTRL_BYTES + `USBHP_CTRL_BYTES + `USBHP_SETUP_BYTES;
		st.oscTimer = 5'h1f;
		resetState = st;
	endfunction

	// whole block next state
	always_comb begin
		logic rdAct;
		logic wrAct;
		logic rawStrobe;
		logic csOn;
		logic startAcc;
		logic hostRead;
		logic dmaRd;
		logic dmaWr;
		logic [7:0] curAddr;
		logic [15:0] oldWord;
		logic [15:0] wv;
		usbhp_pkg::usbhp_epcfg_s [15:0] cand;
		rdAct = 1'b0;
		wrAct = 1'b0;
		rawStrobe = 1'b0;
		csOn = 1'b0;
		startAcc = 1'b0;
		hostRead = 1'b0;
		dmaRd = 1'b0;
		dmaWr = 1'b0;
		curAddr = 8'h00;
		oldWord = 16'h0000;
		wv = 16'h0000;
		cand = q.ep;
		d = q;
		d.txPop = 1'b0;
		d.rxWord.valid = 1'b0;

		// straps are caught once, on the first cycle after reset
		if (!q.cfgDone) begin
			d.cfgDone = 1'b1;
			d.busGeneric = hostBusSelect;
			d.strobeSep = strobeStyleSelect;
			d.latchInd = latchStyleSelect;
		end

		// strobe decode by style
		csOn = !cpuIn.csN;
		if (q.strobeSep) begin
			rdAct = !cpuIn.strobeA;
			wrAct = !cpuIn.strobeB;
		end else begin
			rdAct = !cpuIn.strobeB && cpuIn.strobeA;
			wrAct = !cpuIn.strobeB && !cpuIn.strobeA;
		end
		rawStrobe = (rdAct || wrAct) && q.cfgDone;

		// latch strobe style keeps following the local lines while it is high
		if (!q.busGeneric && !q.latchInd && cpuIn.aleOrIndicator) begin
			d.addrLatch = cpuIn.ad;
		end
		curAddr = q.busGeneric ? cpuIn.ad : q.addrLatch;

		// access tracking: chip select must stay low from start to end
		startAcc = rawStrobe && !q.strobePrev;
		d.strobePrev = rawStrobe;
		if (startAcc) begin
			d.accValid = csOn;
			d.accWrite = wrAct;
			d.accAddr = curAddr;
			d.accAddrPhase = !q.busGeneric && q.latchInd && cpuIn.aleOrIndicator;
			d.rdData = regWord(q, curAddr);
		end else if (rawStrobe && !csOn) begin
			d.accValid = 1'b0;
		end
		if (rawStrobe && wrAct) begin
			d.wrData = q.busGeneric ? dataIn : {8'h00, cpuIn.ad};
		end
		hostRead = rawStrobe && csOn && d.accValid && !d.accWrite && !d.accAddrPhase;

		// write commits on the release of the strobe, when data is settled
		if (q.strobePrev && !rawStrobe && q.accValid && q.accWrite) begin
			if (q.accAddrPhase) begin
				d.addrLatch = q.wrData[7:0];
			end else begin
				oldWord = regWord(q, {q.accAddr[7:1], 1'b0});
				if (q.busGeneric) begin
					wv = q.wrData;
				end else if (q.accAddr[0]) begin
					wv = {q.wrData[7:0], oldWord[7:0]};
				end else begin
					wv = {oldWord[15:8], q.wrData[7:0]};
				end
				case ({q.accAddr[7:1], 1'b0})
					`USBHP_REG_EP_SEL: d.epSel = wv[3:0];
					`USBHP_REG_EP_CFG: begin
						if (!isCtrl(q.epSel)) begin
							cand[q.epSel].enable = wv[`USBHP_EPCFG_EN_BIT];
							cand[q.epSel].dblBuf = wv[`USBHP_EPCFG_DBL_BIT];
							cand[q.epSel].epType = wv[`USBHP_EPCFG_TYPE_HI:`USBHP_EPCFG_TYPE_LO];
							cand[q.epSel].maxPkt = wv[`USBHP_EPCFG_PKT_HI:0];
							// a setting that would overrun the buffer is refused whole
							if (allocSum(cand) <= `USBHP_BUF_BYTES) begin
								d.ep = cand;
								d.allocRefused = 1'b0;
							end else begin
								d.allocRefused = 1'b1;
							end
						end
					end
					`USBHP_REG_DMA_CMD: begin
						d.dmaArmed = 1'b1;
						d.dmaDirOut = wv[`USBHP_DMACMD_DIR_BIT];
						d.dmaMaster = wv[`USBHP_DMACMD_MASTER_BIT] && !q.busGeneric;
						d.dmaTimer = 4'h0;
						if (q.dmaCount == 16'h0000) begin
							d.dmaState = usbhp_pkg::DMA_IDLE;
						end else if (d.dmaMaster) begin
							d.dmaState = usbhp_pkg::DMA_M_ON;
						end else begin
							d.dmaState = usbhp_pkg::DMA_SLAVE;
						end
					end
					`USBHP_REG_DMA_COUNT: d.dmaCount = wv;
					default: begin
					end
				endcase
			end
		end
		d.allocBytes = allocSum(d.ep);

		// dma engine; host reads in generic mode keep the wide lines for themselves
		dmaRd = !dmaReadStrobeN;
		dmaWr = !dmaWriteStrobeN;
		d.dmaRdPrev = dmaRd;
		d.dmaWrPrev = dmaWr;
		case (q.dmaState)
			usbhp_pkg::DMA_IDLE: begin
			end
			usbhp_pkg::DMA_SLAVE: begin
				if (q.dmaDirOut && dmaRd && !q.dmaRdPrev) begin
					d.txWord = dmaTxData;
					d.txPop = 1'b1;
				end
				if (!q.dmaDirOut && dmaWr) begin
					d.dmaLatch = dataIn;
				end
				if ((q.dmaDirOut && !dmaRd && q.dmaRdPrev) ||
					(!q.dmaDirOut && !dmaWr && q.dmaWrPrev)) begin
					d.rxWord.data = q.dmaLatch;
					d.rxWord.valid = !q.dmaDirOut;
					d.dmaCount = q.dmaCount - 16'h0001;
					if (q.dmaCount == 16'h0001) begin
						d.dmaState = usbhp_pkg::DMA_IDLE;
					end
				end
			end
			usbhp_pkg::DMA_M_ON: begin
				d.dmaTimer = q.dmaTimer + 4'h1;
				if (q.dmaTimer == 4'h0 && q.dmaDirOut) begin
					d.txWord = dmaTxData;
					d.txPop = 1'b1;
				end
				if (q.dmaTimer == 4'(`USBHP_DMA_STROBE_CYC - 1)) begin
					d.rxWord.data = dataIn;
					d.rxWord.valid = !q.dmaDirOut;
					d.dmaCount = q.dmaCount - 16'h0001;
					d.dmaTimer = 4'h0;
					d.dmaState = usbhp_pkg::DMA_M_OFF;
				end
			end
			usbhp_pkg::DMA_M_OFF: begin
				d.dmaTimer = q.dmaTimer + 4'h1;
				if (q.dmaTimer == 4'(`USBHP_DMA_GAP_CYC - 1)) begin
					d.dmaTimer = 4'h0;
					if (q.dmaCount == 16'h0000) begin
						d.dmaState = usbhp_pkg::DMA_IDLE;
					end else begin
						d.dmaState = usbhp_pkg::DMA_M_ON;
					end
				end
			end
			default: d.dmaState = usbhp_pkg::DMA_IDLE;
		endcase

		// master strobes are pushed high when idle, never floated
		d.mRdN = !(d.dmaState == usbhp_pkg::DMA_M_ON && !d.dmaDirOut);
		d.mWrN = !(d.dmaState == usbhp_pkg::DMA_M_ON && d.dmaDirOut);

		// pin drive: local lines for split reads, wide lines for generic reads or dma
		d.adOe = hostRead && !q.busGeneric;
		d.adOut = d.accAddr[0] ? d.rdData[15:8] : d.rdData[7:0];
		if (hostRead && q.busGeneric) begin
			d.dataOe = 1'b1;
			d.dataOut = d.rdData;
		end else begin
			d.dataOe = d.dmaArmed && d.dmaDirOut &&
				((d.dmaState == usbhp_pkg::DMA_SLAVE && dmaRd) || d.dmaState == usbhp_pkg::DMA_M_ON);
			d.dataOut = d.txWord;
		end

		// remote wake on a rising edge while suspended
		d.wakePrev = remoteWakeInput;
		d.wakeReq = remoteWakeInput && !q.wakePrev && suspended;

		// reference activity watch; a stopped oscillator means no sampling clock
		d.oscPrev = oscReferenceInput;
		if (oscReferenceInput != q.oscPrev) begin
			d.oscTimer = 5'h00;
		end else if (q.oscTimer != 5'h1f) begin
			d.oscTimer = q.oscTimer + 5'h01;
		end
	end

	// single state register
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			q <= resetState();
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign adOut = q.adOut;
	assign adOe = q.adOe;
	assign dataOut = q.dataOut;
	assign dataOe = q.dataOe;
	assign dmaMasterReadN = q.mRdN;
	assign dmaMasterWriteN = q.mWrN;
	assign dmaTxPop = q.txPop;
	assign dmaRx = q.rxWord;
	assign remoteWakeRequest = q.wakeReq;
	assign epConfig = q.ep;
	assign busGeneric = q.busGeneric;

	a_ctrl_fixed: assert property (@(posedge clk_sys) disable iff (sys_rst)
		q.ep[`USBHP_EP_CTRL_OUT].maxPkt == 11'h040 && q.ep[`USBHP_EP_CTRL_IN].maxPkt == 11'h040)
		else $error("control endpoint size changed");
	a_alloc_limit: assert property (@(posedge clk_sys) disable iff (sys_rst)
		q.allocBytes <= 16'h2000)
		else $error("endpoint buffers exceed memory");
	a_dma_float: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!q.dmaArmed && q.dataOe |-> q.busGeneric && q.adOe == 1'b0)
		else $error("dma bus driven before a command");
	a_split_dmaonly: assert property (@(posedge clk_sys) disable iff (sys_rst)
		q.cfgDone && !q.busGeneric && q.dataOe |-> q.dmaArmed && q.dmaDirOut)
		else $error("wide lines used for registers in split mode");
	a_wake_edge: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(remoteWakeInput) && suspended |=> remoteWakeRequest)
		else $error("remote wake edge lost");
	a_wake_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
		remoteWakeRequest |-> $past(suspended) && !$past(q.wakePrev))
		else $error("wake request without suspended edge");
	a_read_cs: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(q.adOe) |-> !$past(cpuIn.csN))
		else $error("read driven without chip select");
	a_master_split: assert property (@(posedge clk_sys) disable iff (sys_rst)
		q.dmaState == usbhp_pkg::DMA_M_ON |-> !q.busGeneric)
		else $error("dma master in generic mode");
	a_strap_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
		q.cfgDone && $past(q.cfgDone) |-> $stable(q.busGeneric))
		else $error("bus configuration changed after power-up");
	a_strobe_width: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$fell(dmaMasterReadN) |-> !dmaMasterReadN [*3] ##1 dmaMasterReadN)
		else $error("master read strobe width wrong");

endmodule

// [usbhp_dma_party.sv]
module usbhp_dma_party (
	// clock
	input wire logic clk_sys,
	// device side of the wide lines
	input wire logic dataOe,
	input wire logic [15:0] dataOut,
	// host or dma party request to drive
	input wire logic [15:0] hostWord,
	input wire logic hostDrive,
	// resolved level seen by every input
	output logic [15:0] dataLine
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] lastLevel;

	// released lines show the inverse of the last level, so a stale word never passes
	assign dataLine = dataOe ? dataOut : (hostDrive ? hostWord : ~lastLevel);

	// remember the level for the released case
	always @(posedge clk_sys) begin
		lastLevel <= dataLine;
	end
endmodule

// [usbhp_host_bus_port_tb.sv]
`include "usbhp_consts.svh"

module usbhp_host_bus_port_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_sys, sys_rst, hostBusSelect, strobeStyleSelect, latchStyleSelect;
	usbhp_pkg::usbhp_cpuin_s cpuIn;
	logic [7:0] adOut;
	logic adOe, dataOe, hostDrive;
	logic [15:0] dataIn, dataOut, dmaTxData, hostWord, rdWord;
	logic dmaReadStrobeN, dmaWriteStrobeN, dmaMasterReadN, dmaMasterWriteN, dmaTxPop;
	usbhp_pkg::usbhp_word_s dmaRx;
	logic highSpeedDetected, suspended, remoteWakeInput, oscReferenceInput;
	logic remoteWakeRequest, busGeneric;
	usbhp_pkg::usbhp_epcfg_s [15:0] epConfig;
	int fails, totalChecks;

	usbhp_host_bus_port dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.hostBusSelect(hostBusSelect), .strobeStyleSelect(strobeStyleSelect),
		.latchStyleSelect(latchStyleSelect), .cpuIn(cpuIn), .adOut(adOut), .adOe(adOe),
		.dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
		.dmaReadStrobeN(dmaReadStrobeN), .dmaWriteStrobeN(dmaWriteStrobeN),
		.dmaMasterReadN(dmaMasterReadN), .dmaMasterWriteN(dmaMasterWriteN),
		.dmaTxData(dmaTxData), .dmaTxPop(dmaTxPop), .dmaRx(dmaRx),
		.highSpeedDetected(highSpeedDetected), .suspended(suspended),
		.remoteWakeInput(remoteWakeInput), .oscReferenceInput(oscReferenceInput),
		.remoteWakeRequest(remoteWakeRequest), .epConfig(epConfig), .busGeneric(busGeneric));

	usbhp_dma_party party (.clk_sys(clk_sys), .dataOe(dataOe), .dataOut(dataOut),
		.hostWord(hostWord), .hostDrive(hostDrive), .dataLine(dataIn));

	// free running system clock
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		totalChecks++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wrapUp();
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// processor write; split mode adds a latch phase, strobe pair follows the style strap
	task automatic cpuWrite(input logic [7:0] addr, input logic [15:0] data, input logic csN);
		@(posedge clk_sys);
		if (!hostBusSelect) begin
			cpuIn.aleOrIndicator <= 1'b1;
			cpuIn.ad <= addr;
			@(posedge clk_sys);
			cpuIn.aleOrIndicator <= 1'b0;
			cpuIn.ad <= data[7:0];
		end else begin
			cpuIn.ad <= addr;
			hostWord <= data;
			hostDrive <= 1'b1;
		end
		cpuIn.csN <= csN;
		cpuIn.strobeA <= strobeStyleSelect;
		cpuIn.strobeB <= 1'b0;
		repeat (2) @(posedge clk_sys);
		cpuIn.strobeA <= 1'b1;
		cpuIn.strobeB <= 1'b1;
		cpuIn.csN <= 1'b1;
		if (hostBusSelect) begin
			hostDrive <= 1'b0;
		end
		repeat (3) @(posedge clk_sys);
	endtask

	// processor read; host leaves the wide lines to the device
	task automatic cpuRead(input logic [7:0] addr, output logic [15:0] data);
		@(posedge clk_sys);
		if (!hostBusSelect) begin
			cpuIn.aleOrIndicator <= 1'b1;
			cpuIn.ad <= addr;
			@(posedge clk_sys);
			cpuIn.aleOrIndicator <= 1'b0;
		end
		cpuIn.csN <= 1'b0;
		cpuIn.strobeA <= !strobeStyleSelect;
		cpuIn.strobeB <= strobeStyleSelect;
		cpuIn.ad <= addr;
		repeat (2) @(posedge clk_sys);
		#1;
		data = hostBusSelect ? dataOut : {8'h00, adOut};
		check({15'h0000, hostBusSelect ? dataOe : adOe}, 16'h0001, "read drive");
		@(posedge clk_sys);
		cpuIn.strobeA <= 1'b1;
		cpuIn.strobeB <= 1'b1;
		cpuIn.csN <= 1'b1;
		@(posedge clk_sys);
	endtask

	task automatic testReset();
		#1;
		check({15'h0000, busGeneric}, 16'h0001, "strap capture");
		check({14'h0000, dataOe, adOe}, 16'h0000, "lines idle");
		check({14'h0000, dmaMasterReadN, dmaMasterWriteN}, 16'h0003, "strobes idle");
		check({1'b0, epConfig[0]}, 16'h0040, "ctrl out size");
		check({1'b0, epConfig[8]}, 16'h0040, "ctrl in size");
		check({1'b0, epConfig[5]}, 16'h0000, "data ep off");
		$display("test reset done");
	endtask

	task automatic testStatus();
		cpuRead(`USBHP_REG_STATUS, rdWord);
		check(rdWord & 16'h3f0f, 16'h280f, "status straps and pll");
		$display("test status done");
	endtask

	task automatic testEndpoints();
		cpuWrite(`USBHP_REG_EP_SEL, 16'h0001, 1'b0); // processor does the set-up
		cpuWrite(`USBHP_REG_EP_CFG, 16'ha200, 1'b0);
		check({1'b0, epConfig[1]}, 16'h5200, "ep1 config");
		cpuRead(`USBHP_REG_ALLOC, rdWord);
		check(rdWord, 16'h0288, "alloc one ep");
		cpuWrite(`USBHP_REG_EP_SEL, 16'h0002, 1'b0);
		cpuWrite(`USBHP_REG_EP_CFG, 16'hc7ff, 1'b0);
		check({1'b0, epConfig[2]}, 16'h67ff, "ep2 double");
		cpuWrite(`USBHP_REG_EP_SEL, 16'h0003, 1'b0);
		cpuWrite(`USBHP_REG_EP_CFG, 16'hc7ff, 1'b0);
		check({1'b0, epConfig[3]}, 16'h0000, "ep3 over budget");
		cpuRead(`USBHP_REG_ALLOC, rdWord);
		check(rdWord, 16'h1286, "alloc kept");
		cpuRead(`USBHP_REG_STATUS, rdWord);
		check(rdWord & 16'h4000, 16'h4000, "refusal flag");
		cpuWrite(`USBHP_REG_EP_SEL, 16'h0000, 1'b0);
		cpuWrite(`USBHP_REG_EP_CFG, 16'h8100, 1'b0);
		check({1'b0, epConfig[0]}, 16'h0040, "ctrl size fixed");
		$display("test endpoints done");
	endtask

	task automatic testChipSelect();
		cpuWrite(`USBHP_REG_EP_SEL, 16'h0005, 1'b1);
		cpuRead(`USBHP_REG_EP_SEL, rdWord);
		check(rdWord & 16'h000f, 16'h0000, "write without select");
		$display("test chip select done");
	endtask

	task automatic testWake();
		@(posedge clk_sys);
		suspended <= 1'b1;
		remoteWakeInput <= 1'b1;
		#1;
		check({15'h0000, remoteWakeRequest}, 16'h0000, "wake early");
		@(posedge clk_sys);
		#1;
		check({15'h0000, remoteWakeRequest}, 16'h0001, "wake pulse");
		@(posedge clk_sys);
		#1;
		check({15'h0000, remoteWakeRequest}, 16'h0000, "wake one cycle");
		@(posedge clk_sys);
		remoteWakeInput <= 1'b0;
		suspended <= 1'b0;
		repeat (2) @(posedge clk_sys);
		remoteWakeInput <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		check({15'h0000, remoteWakeRequest}, 16'h0000, "wake while awake");
		$display("test wake done");
	endtask

	task automatic testDmaSlave();
		check({15'h0000, dataOe}, 16'h0000, "dma bus idle");
		@(posedge clk_sys);
		dmaTxData <= 16'h5a3c;
		cpuWrite(`USBHP_REG_DMA_COUNT, 16'h0001, 1'b0);
		cpuWrite(`USBHP_REG_DMA_CMD, 16'h0003, 1'b0);
		dmaReadStrobeN <= 1'b0;
		@(posedge clk_sys);
		#1;
		check({15'h0000, dmaTxPop}, 16'h0001, "dma pop");
		@(posedge clk_sys);
		#1;
		check({15'h0000, dmaTxPop}, 16'h0000, "dma pop once");
		check({15'h0000, dataOe}, 16'h0001, "dma drive");
		check(dataOut, 16'h5a3c, "dma word");
		check({14'h0000, dmaMasterReadN, dmaMasterWriteN}, 16'h0003, "no master");
		@(posedge clk_sys);
		dmaReadStrobeN <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		check({15'h0000, dataOe}, 16'h0000, "dma release");
		$display("test dma slave done");
	endtask

	// second power-up: split bus, latch strobe, direction plus data strobe
	task automatic testSplit();
		int lowRd;
		int lowWr;
		int words;
		lowRd = 0;
		lowWr = 0;
		words = 0;
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		hostBusSelect <= 1'b0;
		strobeStyleSelect <= 1'b0;
		latchStyleSelect <= 1'b0;
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		check({15'h0000, busGeneric}, 16'h0000, "split strap");
		check({15'h0000, dataOe}, 16'h0000, "split wide idle");
		cpuWrite(`USBHP_REG_DMA_COUNT, 16'h0002, 1'b0);
		cpuRead(`USBHP_REG_DMA_COUNT, rdWord);
		check(rdWord, 16'h0002, "split count byte");
		cpuRead(`USBHP_REG_STATUS + 8'h01, rdWord);
		check(rdWord, 16'h0028, "split status high");
		cpuRead(`USBHP_REG_STATUS, rdWord);
		check(rdWord, 16'h0008, "split status low");
		// the dma party drives the wide lines for a master read
		hostWord <= 16'hbeef;
		hostDrive <= 1'b1;
		fork
			cpuWrite(`USBHP_REG_DMA_CMD, 16'h0002, 1'b0);
			repeat (24) begin
				@(posedge clk_sys);
				#1;
				lowRd += !dmaMasterReadN;
				lowWr += !dmaMasterWriteN;
				if (dmaRx.valid) begin
					check(dmaRx.data, 16'hbeef, "master word");
					words++;
				end
			end
		join
		check(16'(lowRd), 16'(2 * `USBHP_DMA_STROBE_CYC), "master strobe cycles");
		check(16'(lowWr), 16'h0000, "master write idle");
		check(16'(words), 16'h0002, "master word count");
		@(posedge clk_sys);
		hostDrive <= 1'b0;
		$display("test split done");
	endtask

	// main sequence; the generic strap keeps latch style high
	initial begin
		fails = 0;
		totalChecks = 0;
		sys_rst = 1'b1;
		hostBusSelect = 1'b1;
		strobeStyleSelect = 1'b1;
		latchStyleSelect = 1'b1;
		cpuIn = '{csN: 1'b1, strobeA: 1'b1, strobeB: 1'b1, aleOrIndicator: 1'b0, ad: 8'h00};
		hostWord = 16'h0000;
		hostDrive = 1'b0;
		dmaTxData = 16'h0000;
		dmaReadStrobeN = 1'b1;
		dmaWriteStrobeN = 1'b1;
		highSpeedDetected = 1'b1;
		suspended = 1'b0;
		remoteWakeInput = 1'b0;
		oscReferenceInput = 1'b0;
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		testReset();
		testStatus();
		testEndpoints();
		testChipSelect();
		testWake();
		testDmaSlave();
		testSplit();
		wrapUp();
	end

	// the run needs well under a thousand cycles
	initial begin
		#100us;
		fails++;
		$display("Error at %0t: watchdog expired", $time);
		wrapUp();
	end
endmodule
